// >>> design/mem_ecc_guard.sv
// Purpose: ecc decode and fault logging for flash and system ram reads, error injection for ram reads
// Assumes: all inputs except the clock and voltage monitor flags are on sys_clk
// Notes:   funcRst is a one-cycle functional reset that spares the failure sources
`timescale 1ns/1ps
`default_nettype none
module mem_ecc_guard
  import mem_ecc_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic              funcRst,
  input  wire rdReq_s            flashReq,
  output logic [DATA_W-1:0]      flashData_ff,
  output logic                   flashValid_ff,
  output logic                   flashDbl_ff,
  output logic                   flashIrq_ff,
  input  wire logic              flashIrqEn,
  input  wire logic              flashClr,
  input  wire rdReq_s            ramReq,
  output logic [DATA_W-1:0]      ramData_ff,
  output logic                   ramValid_ff,
  input  wire logic [DATA_W-1:0] ramWrData,
  output logic [CW_W-1:0]        ramWrCw_ff,
  input  wire logic              injEn,
  input  wire logic [CW_W-1:0]   injMask,
  input  wire logic              ramReportEn,
  input  wire logic              ermIrqEn,
  input  wire logic              ermClr,
  output errRec_s                ermRec_ff,
  output logic                   ermIrq_ff,
  input  wire logic              miscEn,
  input  wire logic              miscClr,
  output logic                   miscSbe_ff,
  output logic                   miscDbe_ff,
  input  wire logic              clkFailIn,
  input  wire logic              voltFailIn,
  input  wire logic              failClr,
  output logic [1:0]             failSrc_ff
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic            inRegion;
  logic [CW_W-1:0] ramCw;
  logic [1:0]      flashCls;
  logic [1:0]      ramCls;
  logic            ramSgl;
  logic            ramDbl;

  always_comb begin
    inRegion = (ramReq.addr >= CFG_RAM_BASE) &&
               (ramReq.addr < CFG_RAM_BASE + CFG_RAM_BYTES);
    ramCw    = injEn ? (ramReq.cw ^ injMask) : ramReq.cw;
    flashCls = ecc_class(flashReq.cw);
    ramCls   = ecc_class(ramCw);
    ramSgl   = ramReq.valid && !inRegion && ramCls[0];
    ramDbl   = ramReq.valid && !inRegion && ramCls[1];
  end

  // ----------------------------------------------------------------
  // flash read path
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] nxt_flashData;
  logic              nxt_flashValid;
  logic              nxt_flashDbl;

  always_comb begin
    nxt_flashData  = flashReq.valid ? ecc_correct(flashReq.cw) : flashData_ff;
    nxt_flashValid = flashReq.valid;
    nxt_flashDbl   = flashDbl_ff;
    if (flashClr || funcRst) nxt_flashDbl = 1'b0;
    // a new fault beats a clear in the same cycle
    if (flashReq.valid && flashCls[1]) nxt_flashDbl = 1'b1;
    if (funcRst) nxt_flashValid = 1'b0;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      flashData_ff  <= '0;
      flashValid_ff <= 1'b0;
      flashDbl_ff   <= 1'b0;
      flashIrq_ff   <= 1'b0;
    end else begin
      flashData_ff  <= nxt_flashData;
      flashValid_ff <= nxt_flashValid;
      flashDbl_ff   <= nxt_flashDbl;
      flashIrq_ff   <= nxt_flashDbl && flashIrqEn;
    end
  end

  // ----------------------------------------------------------------
  // system ram path
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] nxt_ramData;

  always_comb begin
    nxt_ramData = ramData_ff;
    if (ramReq.valid) begin
      // the configurable region stores bare words in the low bits
      nxt_ramData = inRegion ? ramReq.cw[DATA_W-1:0] : ecc_correct(ramCw);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ramData_ff  <= '0;
      ramValid_ff <= 1'b0;
      ramWrCw_ff  <= '0;
    end else begin
      ramData_ff  <= nxt_ramData;
      ramValid_ff <= ramReq.valid && !funcRst;
      ramWrCw_ff  <= ecc_encode(ramWrData);
    end
  end

  // ----------------------------------------------------------------
  // error report unit
  // ----------------------------------------------------------------
  errRec_s nxt_ermRec;
  logic    ermLoad;

  always_comb begin
    nxt_ermRec = ermRec_ff;
    if (ermClr || funcRst) nxt_ermRec = ERR_REC_RST;
    // single record may be upgraded by a double, a double is never replaced
    ermLoad = ramReportEn && (ramSgl || ramDbl) &&
              (!nxt_ermRec.valid || (ramDbl && !nxt_ermRec.dbl));
    if (ermLoad) begin
      nxt_ermRec.valid = 1'b1;
      nxt_ermRec.dbl   = ramDbl;
      nxt_ermRec.addr  = ramReq.addr;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ermRec_ff <= ERR_REC_RST;
      ermIrq_ff <= 1'b0;
    end else begin
      ermRec_ff <= nxt_ermRec;
      ermIrq_ff <= nxt_ermRec.valid && ermIrqEn;
    end
  end

  // ----------------------------------------------------------------
  // platform misc control
  // ----------------------------------------------------------------
  logic nxt_miscSbe;
  logic nxt_miscDbe;

  always_comb begin
    nxt_miscSbe = (miscClr || funcRst) ? 1'b0 : miscSbe_ff;
    nxt_miscDbe = (miscClr || funcRst) ? 1'b0 : miscDbe_ff;
    if (miscEn && ramSgl) nxt_miscSbe = 1'b1;
    if (miscEn && ramDbl) nxt_miscDbe = 1'b1;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      miscSbe_ff <= 1'b0;
      miscDbe_ff <= 1'b0;
    end else begin
      miscSbe_ff <= nxt_miscSbe;
      miscDbe_ff <= nxt_miscDbe;
    end
  end

  // ----------------------------------------------------------------
  // failure sources
  // ----------------------------------------------------------------
  // monitor flags are asynchronous; only nrst and failClr clear these, never funcRst
  logic [1:0] failMeta_ff;
  logic [1:0] failSync_ff;
  logic [1:0] nxt_failSrc;

  always_comb begin
    nxt_failSrc = (failClr ? 2'h0 : failSrc_ff) | failSync_ff;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      failMeta_ff <= FAIL_SRC_RST;
      failSync_ff <= FAIL_SRC_RST;
      failSrc_ff  <= FAIL_SRC_RST;
    end else begin
      failMeta_ff[FAIL_CLK_BIT]  <= clkFailIn;
      failMeta_ff[FAIL_VOLT_BIT] <= voltFailIn;
      failSync_ff <= failMeta_ff;
      failSrc_ff  <= nxt_failSrc;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence ramErrSeq;
    ramReq.valid && !inRegion && (ramCls != 2'h0) && ramReportEn && !funcRst;
  endsequence

  sequence ermEmptySeq;
    !ermRec_ff.valid && !ermClr;
  endsequence

  region_bypass_a: assert property (ramReq.valid && inRegion |=>
    ramData_ff == $past(ramReq.cw[DATA_W-1:0]) && ermRec_ff == $past(ermRec_ff)
    || $past(ermClr) || $past(funcRst)) else $error("region read altered");

  flash_dbl_a: assert property (flashReq.valid && flashCls[1] |=>
    flashDbl_ff && (flashIrq_ff == $past(flashIrqEn))) else $error("flash fault lost");

  flash_silent_a: assert property (flashReq.valid && flashCls == 2'h1 &&
    !flashDbl_ff && !flashClr |=> !flashDbl_ff && !flashIrq_ff &&
    flashData_ff == ecc_correct($past(flashReq.cw))) else $error("flash single flagged");

  erm_log_a: assert property (ramErrSeq and ermEmptySeq |=>
    ermRec_ff.valid && ermRec_ff.addr == $past(ramReq.addr) &&
    ermRec_ff.dbl == $past(ramCls[1]) && ermIrq_ff == $past(ermIrqEn))
    else $error("ram error not logged");

  misc_log_a: assert property (miscEn && ramDbl && !funcRst |=> miscDbe_ff [*1])
    else $error("misc double not recorded");

  inject_flip_a: assert property (ramReq.valid && !inRegion && injEn &&
    $onehot(injMask) && ecc_class(ramReq.cw) == 2'h0 ##0 ramErrSeq ##0 ermEmptySeq
    |=> ermRec_ff.valid && !ermRec_ff.dbl &&
    ramData_ff == ecc_correct($past(ramReq.cw))) else $error("injection not seen");

  fail_keep_a: assert property (funcRst && !failClr |=>
    (failSrc_ff & $past(failSrc_ff)) == $past(failSrc_ff))
    else $error("failure source lost");

  dbl_hold_a: assert property (ermRec_ff.valid && ermRec_ff.dbl && !ermClr && !funcRst
    |=> $stable(ermRec_ff)) else $error("double record overwritten");

endmodule : mem_ecc_guard
`default_nettype wire

// >>> pkg/mem_ecc_pkg.sv
// Purpose: shared constants, carriers and ecc functions for the memory ecc guard
// Assumes: 32-bit data words protected by a 39-bit extended hamming codeword
// Notes:   codeword bit 0 is overall parity, power-of-two positions hold check bits
package mem_ecc_pkg;

  localparam int          DATA_W          = 32;
  localparam int          CW_W            = 39;
  localparam int          SYN_W           = 6;
  localparam int          ADDR_W          = 32;
  localparam logic [31:0] CFG_RAM_BASE    = 32'h1400_0000;
  localparam int          CFG_RAM_SIZE_KB = 4;
  localparam logic [31:0] CFG_RAM_BYTES   = 32'(CFG_RAM_SIZE_KB * 1024);
  localparam int          FAIL_CLK_BIT    = 0;
  localparam int          FAIL_VOLT_BIT   = 1;
  localparam logic [1:0]  FAIL_SRC_RST    = 2'h0;

  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
    logic [CW_W-1:0]   cw;
  } rdReq_s;

  typedef struct packed {
    logic              valid;
    logic              dbl;
    logic [ADDR_W-1:0] addr;
  } errRec_s;

  localparam errRec_s ERR_REC_RST = '0;

  function automatic logic [SYN_W-1:0] ecc_syndrome(input logic [CW_W-1:0] cw);
    logic [SYN_W-1:0] syn;
    syn = '0;
    for (int i = 1; i < CW_W; i++) if (cw[i]) syn ^= SYN_W'(i);
    return syn;
  endfunction : ecc_syndrome

  function automatic logic [CW_W-1:0] ecc_encode(input logic [DATA_W-1:0] d);
    logic [CW_W-1:0]  cw;
    logic [SYN_W-1:0] syn;
    int               k;
    cw = '0;
    k  = 0;
    for (int i = 1; i < CW_W; i++) begin
      if ((i & (i - 1)) != 0) begin
        cw[i] = d[k];
        k++;
      end
    end
    syn = ecc_syndrome(cw);
    for (int b = 0; b < SYN_W; b++) cw[1 << b] = syn[b];
    cw[0] = ^cw;
    return cw;
  endfunction : ecc_encode

  // single errors are flipped back; double errors leave data as stored
  function automatic logic [DATA_W-1:0] ecc_correct(input logic [CW_W-1:0] cwIn);
    logic [CW_W-1:0]   cw;
    logic [SYN_W-1:0]  syn;
    logic [DATA_W-1:0] d;
    int                k;
    cw  = cwIn;
    syn = ecc_syndrome(cw);
    d   = '0;
    k   = 0;
    if ((^cw) && (int'(syn) < CW_W)) cw[syn] = ~cw[syn];
    for (int i = 1; i < CW_W; i++) begin
      if ((i & (i - 1)) != 0) begin
        d[k] = cw[i];
        k++;
      end
    end
    return d;
  endfunction : ecc_correct

  // returns {double, single}
  function automatic logic [1:0] ecc_class(input logic [CW_W-1:0] cw);
    logic [SYN_W-1:0] syn;
    logic             par;
    syn = ecc_syndrome(cw);
    par = ^cw;
    if (par && (int'(syn) < CW_W)) return 2'h1;
    if (par || (syn != '0)) return 2'h2;
    return 2'h0;
  endfunction : ecc_class

endpackage : mem_ecc_pkg

// >>> sim/mem_reader_model.sv
// Purpose: bus master side that presents coded read words to the guard
// Assumes: bench toggles go on the falling edge, one word per request
// Notes:   idle bus shows inverted codeword so stale data never looks valid
`timescale 1ns/1ps
`default_nettype none
module mem_reader_model
  import mem_ecc_pkg::*;
(
  input  wire logic              go,
  input  wire logic              isRam,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] data,
  input  wire logic [CW_W-1:0]   flip,
  output rdReq_s                 flashReq,
  output rdReq_s                 ramReq
);
  logic   inRegion;
  rdReq_s req;
  // region words are stored raw, so no code bits are made for them
  assign inRegion = (addr - CFG_RAM_BASE) < CFG_RAM_BYTES;
  always_comb begin
    req.valid = go;
    req.addr  = addr;
    req.cw    = inRegion ? {7'h0, data} : ecc_encode(data) ^ flip;
    if (!go) begin
      req.cw = ~req.cw;
    end
    flashReq       = req;
    flashReq.valid = go & ~isRam;
    ramReq         = req;
    ramReq.valid   = go & isRam;
  end
endmodule : mem_reader_model
`default_nettype wire

// >>> sim/tb_memory_ecc_error_reporting.sv
// Purpose: self-checking bench for the memory ecc guard
// Assumes: inputs change on the falling edge, answers one edge after a request
// Notes:   ram write encoder judged against a hand-worked codeword
`timescale 1ns/1ps
`default_nettype none
module tb_memory_ecc_error_reporting;
  import mem_ecc_pkg::*;
  logic sys_clk, nrst, funcRst, go, isRam;
  logic flashIrqEn, flashClr, injEn, ramReportEn, ermIrqEn, ermClr;
  logic miscEn, miscClr, clkFailIn, voltFailIn, failClr;
  logic [31:0] addr, data, flashData, ramData;
  logic [38:0] flip, injMask;
  logic [31:0] ramWrData;
  logic [38:0] ramWrCw;
  logic flashValid, flashDbl, flashIrq, ramValid, ermIrq, miscSbe, miscDbe;
  logic [1:0] failSrc;
  rdReq_s flashReq, ramReq;
  errRec_s ermRec;
  int n_errors = 0;
  int n_checks = 0;
  mem_reader_model u_mem_reader_model (.go(go), .isRam(isRam), .addr(addr),
    .data(data), .flip(flip), .flashReq(flashReq), .ramReq(ramReq));
  mem_ecc_guard u_mem_ecc_guard (.sys_clk(sys_clk), .nrst(nrst), .funcRst(funcRst),
    .flashReq(flashReq), .flashData_ff(flashData), .flashValid_ff(flashValid),
    .flashDbl_ff(flashDbl), .flashIrq_ff(flashIrq), .flashIrqEn(flashIrqEn),
    .flashClr(flashClr), .ramReq(ramReq), .ramData_ff(ramData),
    .ramValid_ff(ramValid), .ramWrData(ramWrData), .ramWrCw_ff(ramWrCw), .injEn(injEn),
    .injMask(injMask), .ramReportEn(ramReportEn), .ermIrqEn(ermIrqEn),
    .ermClr(ermClr), .ermRec_ff(ermRec), .ermIrq_ff(ermIrq), .miscEn(miscEn),
    .miscClr(miscClr), .miscSbe_ff(miscSbe), .miscDbe_ff(miscDbe),
    .clkFailIn(clkFailIn), .voltFailIn(voltFailIn), .failClr(failClr),
    .failSrc_ff(failSrc));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic chk(string nm, logic [63:0] exp, logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  // one word: taken and answered at the next rising edge, checked at the falling edge after
  task automatic rd(logic r, logic [31:0] a, d, logic [38:0] f);
    go = 1'b1; isRam = r; addr = a; data = d; flip = f;
    @(negedge sys_clk);
    // valid stands only until the next rising edge
    chk("valid", 1, r ? ramValid : flashValid);
    go = 1'b0;
    @(negedge sys_clk);
  endtask : rd
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge sys_clk);
    s = 1'b0;
    @(negedge sys_clk);
  endtask : pulse
  task automatic t_flash();
    flashIrqEn = 1'b1;
    rd(1'b0, 32'h100, 32'h5a5a_0f0f, 39'h80);
    chk("fvalid", 0, flashValid);
    chk("fdata", 32'h5a5a_0f0f, flashData);
    chk("fquiet", 0, {flashDbl, flashIrq});
    rd(1'b0, 32'h104, 32'h1234_5678, 39'h208);
    chk("fdbl", 2'h3, {flashDbl, flashIrq});
    pulse(flashClr);
    chk("fclr", 0, {flashDbl, flashIrq});
    flashIrqEn = 1'b0;
    rd(1'b0, 32'h108, 32'h1234_5678, 39'h208);
    chk("fnoirq", 2'h2, {flashDbl, flashIrq});
    // uncorrectable fault: software forces the safe state by functional reset
    pulse(funcRst);
    chk("fsafe", 0, {flashDbl, flashIrq});
  endtask : t_flash
  task automatic t_ram();
    injEn = 1'b1;
    injMask = 39'h1000;
    rd(1'b1, 32'h2000_0010, 32'hcafe_0001, 39'h0);
    chk("rdata", 32'hcafe_0001, ramData);
    chk("rsbe", {1'b1, 1'b0, 32'h2000_0010}, ermRec);
    chk("rirq", 3'h6, {ermIrq, miscSbe, miscDbe});
    injMask = 39'h1100;
    rd(1'b1, 32'h2000_0020, 32'hcafe_0002, 39'h0);
    chk("rdbe", {1'b1, 1'b1, 32'h2000_0020}, ermRec);
    chk("mdbe", 1, miscDbe);
    injMask = 39'h2;
    rd(1'b1, 32'h2000_0030, 32'hcafe_0003, 39'h0);
    chk("rhold", {1'b1, 1'b1, 32'h2000_0020}, ermRec);
    pulse(ermClr);
    chk("rclr", 0, {ermRec, ermIrq});
    pulse(miscClr);
    chk("mclr", 0, {miscSbe, miscDbe});
    rd(1'b1, 32'h1400_0ffc, 32'hbeef_0004, 39'h0);
    chk("cdata", 32'hbeef_0004, ramData);
    chk("clog", 0, ermRec);
    ermIrqEn = 1'b0;
    injMask = 39'h4;
    rd(1'b1, 32'h2000_0040, 32'hcafe_0005, 39'h0);
    chk("rlog2", {1'b1, 1'b0, 32'h2000_0040}, ermRec);
    chk("rquiet", 3'h2, {ermIrq, miscSbe, miscDbe});
    // data bit 0 sits at position 3, so check bits 1, 2 and parity are set
    ramWrData = 32'h1;
    @(negedge sys_clk);
    chk("wrcw", 39'h0f, ramWrCw);
    injEn = 1'b0;
  endtask : t_ram
  task automatic t_fail();
    clkFailIn = 1'b1;
    voltFailIn = 1'b1;
    repeat (4) @(negedge sys_clk);
    clkFailIn = 1'b0;
    voltFailIn = 1'b0;
    chk("fsrc", 2'h3, failSrc);
    pulse(funcRst);
    chk("fkeep", 2'h3, failSrc);
    chk("mrst", 0, {miscSbe, miscDbe});
    chk("erst", 0, ermRec);
    pulse(failClr);
    chk("fgone", 0, failSrc);
  endtask : t_fail
  initial begin
    nrst = 1'b0; funcRst = 1'b0; go = 1'b0; isRam = 1'b0;
    addr = 32'h0; data = 32'h0; flip = 39'h0; injMask = 39'h0; injEn = 1'b0;
    ramWrData = 32'h0;
    flashIrqEn = 1'b0; flashClr = 1'b0; ermClr = 1'b0; miscClr = 1'b0;
    clkFailIn = 1'b0; voltFailIn = 1'b0; failClr = 1'b0;
    // reporting is armed before any traffic, as software must do
    ramReportEn = 1'b1; ermIrqEn = 1'b1; miscEn = 1'b1;
    repeat (4) @(negedge sys_clk);
    nrst = 1'b1;
    @(negedge sys_clk);
    t_flash();
    t_ram();
    t_fail();
    end_of_test();
  end
  initial begin
    #200us;
    n_errors++;
    end_of_test();
  end
endmodule : tb_memory_ecc_error_reporting
`default_nettype wire
